// ---- src/alu_status_pkg.sv ----
// package: constants, types and register map of the alu status block
package alu_status_pkg;

  // register offsets
  localparam logic [7:0] ALU_FLAGS_OFFSET = 8'h04;
  localparam logic [7:0] CPU_STATE_OFFSET = 8'h06;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h40;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h41;

  // alu flag register field positions
  localparam int CARRY_BIT = 0;
  localparam int NIBBLE_BIT = 1;
  localparam int ZERO_BIT = 2;
  localparam int RANGE_BIT = 3;

  // cpu state register field positions
  localparam int DIP_BIT = 0;
  localparam int POWER_ON_BIT = 1;
  localparam int SLEEP_BIT = 2;
  localparam int EXPIRED_BIT = 3;
  localparam int GLOBAL_OFF_BIT = 4;
  localparam int STACK_ROOM_BIT = 5;

  // reset values and stack full limit
  localparam logic [3:0] MODE_RESET = 4'hf;
  localparam logic [3:0] STACK_FULL = 4'hf;
  localparam logic [3:0] STACK_EMPTY = 4'h0;

  // pointer step codes
  localparam logic [1:0] STEP_DEC = 2'h0;
  localparam logic [1:0] STEP_INC = 2'h1;

  // interrupt status event bits
  localparam int EV_EXPIRED = 0;
  localparam int EV_STACK = 1;
  localparam int EV_RANGE = 2;

  typedef enum logic [3:0] {
    OP_NONE, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_INC, OP_DEC,
    OP_CLEAR, OP_BIT_CLEAR, OP_BIT_SET, OP_SWAP, OP_MOVE, OP_PASS
  } alu_op_t;

  typedef struct packed {
    logic valid;
    alu_op_t op;
    logic imm_sel;
    logic single_on_file;
    logic dest_file;
    logic [7:0] file_addr;
    logic [7:0] file_data;
    logic [7:0] imm;
    logic [2:0] bit_sel;
  } instr_t;

  typedef struct packed {
    logic [7:0] value;
    logic carry;
    logic nibble;
    logic zero;
    logic range;
    logic touches_flags;
  } alu_result_t;

endpackage

// ---- src/alu_core.sv ----
// file: combinational 8-bit alu with flag generation
`timescale 1ns/1ps
module alu_core
  import alu_status_pkg::*;
(
  input wire alu_op_t i_op, // operation
  input wire logic [7:0] i_acc, // accumulator
  input wire logic [7:0] i_other, // file register, immediate or accumulator
  input wire logic [2:0] i_bit_sel, // bit index
  input wire logic i_carry_in, // current carry
  output alu_result_t o_res // result with flags
);

  logic [8:0] wide;
  logic [4:0] low;
  logic [7:0] opa;
  logic [7:0] opb;

  // operand prep, subtraction adds the complement plus one
  always_comb begin
    opa = i_acc;
    opb = i_other;
    wide = 9'h000;
    low = 5'h00;
    o_res = '0;
    case (i_op)
      OP_ADD: begin
        wide = {1'b0, opa} + {1'b0, opb};
        low = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
        o_res.value = wide[7:0];
        o_res.carry = wide[8];
        o_res.nibble = low[4];
        o_res.range = (opa[7] == opb[7]) && (wide[7] != opa[7]);
        o_res.touches_flags = 1'b1;
      end
      OP_SUB: begin
        wide = {1'b0, opb} + {1'b0, ~opa} + 9'h001;
        low = {1'b0, opb[3:0]} + {1'b0, ~opa[3:0]} + 5'h01;
        o_res.value = wide[7:0];
        o_res.carry = wide[8];
        o_res.nibble = low[4];
        o_res.range = (opb[7] != opa[7]) && (wide[7] != opb[7]);
        o_res.touches_flags = 1'b1;
      end
      OP_AND: begin
        o_res.value = opa & opb;
        o_res.touches_flags = 1'b1;
      end
      OP_OR: begin
        o_res.value = opa | opb;
        o_res.touches_flags = 1'b1;
      end
      OP_XOR: begin
        o_res.value = opa ^ opb;
        o_res.touches_flags = 1'b1;
      end
      OP_INC: begin
        wide = {1'b0, opb} + 9'h001;
        low = {1'b0, opb[3:0]} + 5'h01;
        o_res.value = wide[7:0];
        o_res.carry = wide[8];
        o_res.nibble = low[4];
        o_res.range = (opb == 8'h7f);
        o_res.touches_flags = 1'b1;
      end
      OP_DEC: begin
        wide = {1'b0, opb} + 9'h0ff;
        low = {1'b0, opb[3:0]} + 5'h0f;
        o_res.value = wide[7:0];
        o_res.carry = wide[8];
        o_res.nibble = low[4];
        o_res.range = (opb == 8'h80);
        o_res.touches_flags = 1'b1;
      end
      OP_BIT_CLEAR: o_res.value = opb & ~(8'h01 << i_bit_sel);
      OP_BIT_SET: o_res.value = opb | (8'h01 << i_bit_sel);
      OP_SWAP: o_res.value = {opb[3:0], opb[7:4]};
      OP_MOVE: o_res.value = opa;
      OP_PASS: o_res.value = opb;
      default: o_res.value = 8'h00;
    endcase
    o_res.zero = (o_res.value == 8'h00);
    if (!o_res.touches_flags) begin
      o_res.carry = i_carry_in;
    end
  end

endmodule // alu_core

// ---- src/alu_status_flags.sv ----
// file: alu flag, pointer mode and cpu state registers with interrupt logic
`timescale 1ns/1ps
module alu_status_flags
  import alu_status_pkg::*;
(
  input wire logic i_clk_sys, // instruction clock
  input wire logic i_rst_n, // synchronous reset, active low
  input wire logic i_por_event, // power-on reset happened
  input wire logic i_pin_reset, // external reset pin reset
  input wire logic i_wdt_reset, // watchdog reset
  input wire logic i_dip_reset, // brown-out reset
  input wire logic i_dip_detect_en, // supply dip detect enable
  input wire instr_t i_instr, // instruction from execution unit
  input wire logic i_sleep_exec, // sleep instruction executed
  input wire logic i_wdt_clear_exec, // watchdog clear executed
  input wire logic i_wdt_timeout, // watchdog time-out
  input wire logic i_stack_push, // stack push
  input wire logic i_stack_pop, // stack pop
  input wire logic i_ptr0_access, // indirect access via pointer 0
  input wire logic i_ptr1_access, // indirect access via pointer 1
  input wire logic [3:0] i_src_pending, // per-source pending
  input wire logic [3:0] i_src_enable, // per-source enables
  input wire logic [7:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // register write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [7:0] o_rdata, // read data, cycle after read
  output logic [7:0] o_result, // alu result
  output logic o_result_valid, // result strobe
  output logic [7:0] o_accumulator, // accumulator value
  output logic [7:0] o_ptr0, // indirect pointer 0
  output logic [7:0] o_ptr1, // indirect pointer 1
  output logic o_cpu_irq, // gated cpu interrupt request
  output logic o_irq // status event interrupt
);

  logic [7:0] alu_flags_reg, alu_flags_next;
  logic [5:0] cpu_state_reg, cpu_state_next;
  logic [3:0] stack_ptr_reg, stack_ptr_next;
  logic [7:0] acc_reg, acc_next;
  logic [7:0] ptr0_reg, ptr0_next;
  logic [7:0] ptr1_reg, ptr1_next;
  logic [7:0] result_reg, result_next;
  logic valid_reg, valid_next;
  logic [2:0] irq_status_reg, irq_status_next;
  logic [2:0] irq_mask_reg, irq_mask_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [1:0] ptr1_step_mode;
  logic [1:0] ptr0_step_mode;
  logic single_op;
  logic [7:0] alu_other;
  logic flag_dest;
  logic cpu_dest;
  logic sw_wr_flags;
  logic sw_wr_cpu;
  logic stack_overflow;
  logic range_event;
  alu_result_t res;

  // pointer step function
  // codes above the increment code hold the pointer, which is the mode after reset
  function automatic logic [7:0] step_ptr(input logic [7:0] p, input logic [1:0] mode);
    if (mode == STEP_DEC) begin
      step_ptr = p - 8'h01;
    end else if (mode == STEP_INC) begin
      step_ptr = p + 8'h01;
    end else begin
      step_ptr = p;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // alu datapath

  assign ptr1_step_mode = alu_flags_reg[7:6];
  assign ptr0_step_mode = alu_flags_reg[5:4];

  // single operand on file or accumulator
  // increment and decrement work on the accumulator unless the file or the immediate is selected
  assign single_op = (i_instr.op == OP_INC) || (i_instr.op == OP_DEC);

  // second operand select
  // the immediate wins over any file operand, so literal forms never read the file bus
  assign alu_other = i_instr.imm_sel ? i_instr.imm :
    (single_op && !i_instr.single_on_file) ? acc_reg : i_instr.file_data;

  alu_core u_alu (
    .i_op(i_instr.op),
    .i_acc(acc_reg),
    .i_other(alu_other),
    .i_bit_sel(i_instr.bit_sel),
    .i_carry_in(alu_flags_reg[CARRY_BIT]),
    .o_res(res)
  );

  // instruction and software may hit one register in one cycle; the instruction wins for the alu flags, the software write for the cpu state
  assign flag_dest = i_instr.valid && i_instr.dest_file && (i_instr.file_addr == ALU_FLAGS_OFFSET);
  assign cpu_dest = i_instr.valid && i_instr.dest_file && (i_instr.file_addr == CPU_STATE_OFFSET);
  assign sw_wr_flags = i_wr && (i_addr == ALU_FLAGS_OFFSET);
  assign sw_wr_cpu = i_wr && (i_addr == CPU_STATE_OFFSET);
  // a push at full wraps the pointer to empty, which is the overflow
  assign stack_overflow = i_stack_push && (stack_ptr_reg == STACK_FULL);
  assign range_event = i_instr.valid && res.touches_flags && res.range;

  // alu flags, accumulator, pointers, result
  always_comb begin
    alu_flags_next = alu_flags_reg;
    acc_next = acc_reg;
    ptr0_next = ptr0_reg;
    ptr1_next = ptr1_reg;
    result_next = result_reg;
    valid_next = 1'b0;
    if (sw_wr_flags) begin
      alu_flags_next = i_wdata;
    end
    if (i_instr.valid) begin
      result_next = res.value;
      valid_next = 1'b1;
      if (i_instr.op == OP_CLEAR) begin
        result_next = 8'h00;
      end
      if (!i_instr.dest_file) begin
        acc_next = (i_instr.op == OP_CLEAR) ? 8'h00 : res.value;
      end else if (flag_dest) begin
        if (i_instr.op == OP_CLEAR) begin
          alu_flags_next[7:4] = 4'h0;
          alu_flags_next[ZERO_BIT] = 1'b1;
        end else if (res.touches_flags) begin
          alu_flags_next[7:4] = res.value[7:4];
        end else begin
          alu_flags_next = res.value;
        end
      end
      if (i_instr.op == OP_CLEAR && !flag_dest) begin
        alu_flags_next[ZERO_BIT] = 1'b1;
      end
      if (res.touches_flags) begin
        alu_flags_next[CARRY_BIT] = res.carry;
        alu_flags_next[NIBBLE_BIT] = res.nibble;
        alu_flags_next[ZERO_BIT] = res.zero;
        alu_flags_next[RANGE_BIT] = res.range;
      end
    end
    // modes come from the registered flags, so a mode write steers the next access, not this one
    if (i_ptr0_access) begin
      ptr0_next = step_ptr(ptr0_reg, ptr0_step_mode);
    end
    if (i_ptr1_access) begin
      ptr1_next = step_ptr(ptr1_reg, ptr1_step_mode);
    end
  end

  // modes reset to hold so pointers stay put until software picks a step
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      alu_flags_reg <= {MODE_RESET, 4'h0};
      acc_reg <= 8'h00;
      ptr0_reg <= 8'h00;
      ptr1_reg <= 8'h00;
      result_reg <= 8'h00;
      valid_reg <= 1'b0;
    end else begin
      alu_flags_reg <= alu_flags_next;
      acc_reg <= acc_next;
      ptr0_reg <= ptr0_next;
      ptr1_reg <= ptr1_next;
      result_reg <= result_next;
      valid_reg <= valid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cpu state register and stack pointer

  // reset causes are sampled on the clock while reset is low, so the flags can tell them apart
  always_comb begin
    cpu_state_next = cpu_state_reg;
    stack_ptr_next = stack_ptr_reg;
    if (!i_rst_n) begin
      stack_ptr_next = STACK_EMPTY;
      cpu_state_next[STACK_ROOM_BIT] = 1'b1;
      cpu_state_next[GLOBAL_OFF_BIT] = 1'b1;
      if (i_por_event) begin
        cpu_state_next[POWER_ON_BIT] = 1'b0;
        // supply dip flag starts as no-dip, so it never reads unknown
        cpu_state_next[DIP_BIT] = 1'b1;
        cpu_state_next[EXPIRED_BIT] = 1'b1;
        cpu_state_next[SLEEP_BIT] = 1'b1;
      end
      // dip marker, left unchanged when detect off
      if (i_dip_reset && i_dip_detect_en) begin
        cpu_state_next[DIP_BIT] = 1'b0;
      end
      if (i_wdt_reset && !i_pin_reset && !i_por_event) begin
        cpu_state_next[EXPIRED_BIT] = 1'b0;
      end
    end else begin
      if (sw_wr_cpu) begin
        cpu_state_next[GLOBAL_OFF_BIT] = i_wdata[GLOBAL_OFF_BIT];
        cpu_state_next[POWER_ON_BIT] = i_wdata[POWER_ON_BIT];
        cpu_state_next[DIP_BIT] = i_wdata[DIP_BIT];
      end else if (cpu_dest) begin
        cpu_state_next[GLOBAL_OFF_BIT] = res.value[GLOBAL_OFF_BIT];
        cpu_state_next[POWER_ON_BIT] = res.value[POWER_ON_BIT];
        cpu_state_next[DIP_BIT] = res.value[DIP_BIT];
      end
      if (i_wdt_clear_exec) begin
        cpu_state_next[EXPIRED_BIT] = 1'b1;
        cpu_state_next[SLEEP_BIT] = 1'b1;
      end
      if (i_sleep_exec) begin
        cpu_state_next[EXPIRED_BIT] = 1'b1;
        cpu_state_next[SLEEP_BIT] = 1'b0;
      end
      // timeout is applied last so it wins over a same-cycle clear or sleep
      if (i_wdt_timeout) begin
        cpu_state_next[EXPIRED_BIT] = 1'b0;
      end
      // push wins over a same-cycle pop
      if (i_stack_push) begin
        stack_ptr_next = stack_ptr_reg + 4'h1;
      end else if (i_stack_pop) begin
        stack_ptr_next = stack_ptr_reg - 4'h1;
      end
      if (stack_overflow || (i_stack_push && stack_ptr_reg == STACK_FULL - 4'h1)) begin
        cpu_state_next[STACK_ROOM_BIT] = 1'b0;
      end
    end
  end

  // runs through reset so the cause flags are captured, constants at power-on
  always_ff @(posedge i_clk_sys) begin
    cpu_state_reg <= cpu_state_next;
    stack_ptr_reg <= stack_ptr_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts and register reads

  // single global bit
  // level, not latched: a source dropping its request drops the line at once
  assign o_cpu_irq = !cpu_state_reg[GLOBAL_OFF_BIT] && |(i_src_pending & i_src_enable);
  assign o_irq = |(irq_status_reg & irq_mask_reg);

  // events set sticky bits, set wins over write-one-to-clear
  always_comb begin
    irq_status_next = irq_status_reg;
    irq_mask_next = irq_mask_reg;
    rdata_next = 8'h00;
    if (i_wr && i_addr == IRQ_STATUS_OFFSET) begin
      irq_status_next = irq_status_reg & ~i_wdata[2:0];
    end
    if (i_wr && i_addr == IRQ_MASK_OFFSET) begin
      irq_mask_next = i_wdata[2:0];
    end
    irq_status_next[EV_EXPIRED] = irq_status_next[EV_EXPIRED] | i_wdt_timeout;
    irq_status_next[EV_STACK] = irq_status_next[EV_STACK] | stack_overflow;
    irq_status_next[EV_RANGE] = irq_status_next[EV_RANGE] | range_event;
    // unmapped reads return zero so software can probe the map safely
    if (i_rd) begin
      if (i_addr == ALU_FLAGS_OFFSET) begin
        rdata_next = alu_flags_reg;
      end else if (i_addr == CPU_STATE_OFFSET) begin
        rdata_next = {2'b00, cpu_state_reg};
      end else if (i_addr == IRQ_STATUS_OFFSET) begin
        rdata_next = {5'h00, irq_status_reg};
      end else if (i_addr == IRQ_MASK_OFFSET) begin
        rdata_next = {5'h00, irq_mask_reg};
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  // mask and status clear on reset so no stale event raises the interrupt
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      irq_status_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
      rdata_reg <= 8'h00;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      rdata_reg <= rdata_next;
    end
  end

  // every data output is a plain register copy
  assign o_rdata = rdata_reg;
  assign o_result = result_reg;
  assign o_result_valid = valid_reg;
  assign o_accumulator = acc_reg;
  assign o_ptr0 = ptr0_reg;
  assign o_ptr1 = ptr1_reg;

endmodule // alu_status_flags

// ---- tb/alu_status_checker_sva.sv ----
// assertion checker for the alu status block ports
`timescale 1ns/1ps
module alu_status_checker
  import alu_status_pkg::*;
(
  input wire logic i_clk_sys, // clock
  input wire logic i_rst_n, // reset, active low
  input wire instr_t i_instr, // instruction
  input wire logic i_ptr0_access, // pointer 0 access
  input wire logic [3:0] i_src_pending, // pending
  input wire logic [3:0] i_src_enable, // enables
  input wire logic [7:0] o_result, // result
  input wire logic o_result_valid, // result strobe
  input wire logic [7:0] o_accumulator, // accumulator
  input wire logic [7:0] o_ptr0, // pointer 0
  input wire logic o_cpu_irq // cpu request
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] add_exp_reg, add_exp_next, sub_exp_reg, sub_exp_next;
  ////////////////////////////////////////////////////////////
  // expected results kept one cycle, since the result is registered
  always_comb begin
    add_exp_next = o_accumulator + i_instr.imm;
    sub_exp_next = i_instr.imm - o_accumulator;
  end
  always_ff @(posedge i_clk_sys) begin
    add_exp_reg <= add_exp_next;
    sub_exp_reg <= sub_exp_next;
  end
  ////////////////////////////////////////////////////////////
  AST_RESULT_STROBE: assert property (i_instr.valid |=> o_result_valid)
    else $error("result strobe missing");
  AST_RESULT_QUIET: assert property (!i_instr.valid |=> !o_result_valid)
    else $error("result strobe without instruction");
  AST_ADD_SUM: assert property (i_instr.valid && i_instr.op == OP_ADD && i_instr.imm_sel
    |=> o_result == add_exp_reg) else $error("add result wrong");
  AST_SUB_DIFF: assert property (i_instr.valid && i_instr.op == OP_SUB && i_instr.imm_sel
    |=> o_result == sub_exp_reg) else $error("subtract result wrong");
  AST_ACC_DEST: assert property (i_instr.valid && i_instr.op inside {OP_ADD, OP_SUB} && !i_instr.dest_file
    |=> o_accumulator == o_result) else $error("accumulator not written");
  AST_ACC_HOLD: assert property (!i_instr.valid |=> $stable(o_accumulator))
    else $error("accumulator moved");
  AST_IRQ_GATE: assert property (o_cpu_irq |-> |(i_src_pending & i_src_enable))
    else $error("cpu request without enabled source");
  AST_PTR0_STEP: assert property (i_ptr0_access |=> o_ptr0 == $past(o_ptr0) + 8'h01
    || o_ptr0 == $past(o_ptr0) - 8'h01 || o_ptr0 == $past(o_ptr0)) else $error("pointer 0 bad step");
  AST_PTR0_HOLD: assert property (!i_ptr0_access && !i_instr.valid |=> $stable(o_ptr0))
    else $error("pointer 0 moved");
endmodule // alu_status_checker

// ---- tb/alu_status_flags_tb.sv ----
// self-checking testbench for the alu status block
`timescale 1ns/1ps
module alu_status_flags_tb;
  import alu_status_pkg::*;
  logic i_clk_sys, i_rst_n, i_por_event, i_pin_reset, i_wdt_reset, i_dip_reset, i_dip_detect_en;
  instr_t i_instr;
  logic i_sleep_exec, i_wdt_clear_exec, i_wdt_timeout, i_stack_push, i_stack_pop, i_ptr0_access, i_ptr1_access;
  logic [3:0] i_src_pending, i_src_enable;
  logic [7:0] i_addr, i_wdata, o_rdata, o_result, o_accumulator, o_ptr0, o_ptr1, d;
  logic i_wr, i_rd, o_result_valid, o_cpu_irq, o_irq;
  int bad_count, n_tests;
  alu_status_flags alu_status_flags_inst (.i_clk_sys, .i_rst_n, .i_por_event, .i_pin_reset, .i_wdt_reset,
    .i_dip_reset, .i_dip_detect_en, .i_instr, .i_sleep_exec, .i_wdt_clear_exec, .i_wdt_timeout, .i_stack_push,
    .i_stack_pop, .i_ptr0_access, .i_ptr1_access, .i_src_pending, .i_src_enable, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .o_result, .o_result_valid, .o_accumulator, .o_ptr0, .o_ptr1, .o_cpu_irq, .o_irq);
  ////////////////////////////////////////////////////////////
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask
  // bus tasks leave a spare edge so no strobe is set twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  task automatic rd(input logic [7:0] a);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    d = o_rdata;
    @(posedge i_clk_sys);
  endtask
  // event pulses: sleep, wdt clear, timeout, push, pop, ptr0, ptr1
  task automatic ev(input logic [6:0] m);
    {i_sleep_exec, i_wdt_clear_exec, i_wdt_timeout, i_stack_push, i_stack_pop, i_ptr0_access, i_ptr1_access} <= m;
    @(posedge i_clk_sys);
    {i_sleep_exec, i_wdt_clear_exec, i_wdt_timeout, i_stack_push, i_stack_pop, i_ptr0_access, i_ptr1_access} <= 7'h00;
    @(posedge i_clk_sys);
  endtask
  task automatic op(input alu_op_t o, input logic [7:0] v, input logic df, input logic ck, input logic [7:0] e);
    i_instr.op <= o;
    i_instr.imm <= v;
    i_instr.dest_file <= df;
    i_instr.file_addr <= df ? ALU_FLAGS_OFFSET : 8'h20;
    i_instr.valid <= 1'b1;
    @(posedge i_clk_sys);
    i_instr.valid <= 1'b0;
    @(negedge i_clk_sys);
    chk("result_valid", 8'h01, {7'h00, o_result_valid});
    if (ck) chk("result", e, o_result);
    @(posedge i_clk_sys);
  endtask
  task automatic do_reset(input logic [3:0] cause);
    {i_por_event, i_pin_reset, i_wdt_reset, i_dip_reset} <= cause;
    i_rst_n <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    {i_por_event, i_pin_reset, i_wdt_reset, i_dip_reset} <= 4'h0;
    @(posedge i_clk_sys);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_arith();
    op(OP_ADD, 8'h7f, 1'b0, 1'b1, 8'h7f);
    op(OP_ADD, 8'h01, 1'b0, 1'b1, 8'h80);
    rd(ALU_FLAGS_OFFSET);
    chk("flags_ovf", 8'hfa, d);
    op(OP_ADD, 8'h80, 1'b0, 1'b1, 8'h00);
    rd(ALU_FLAGS_OFFSET);
    chk("flags_wrap", 8'hfd, d);
    op(OP_SUB, 8'h05, 1'b0, 1'b1, 8'h05);
    rd(ALU_FLAGS_OFFSET);
    chk("flags_noborrow", 8'hf3, d);
    op(OP_SUB, 8'h03, 1'b0, 1'b1, 8'hfe);
    rd(ALU_FLAGS_OFFSET);
    chk("flags_borrow", 8'hf0, d);
    $display("arith done");
  endtask
  task automatic t_flags();
    alu_op_t keep[4] = '{OP_BIT_CLEAR, OP_BIT_SET, OP_SWAP, OP_MOVE};
    op(OP_ADD, 8'h02, 1'b1, 1'b1, 8'h00);
    rd(ALU_FLAGS_OFFSET);
    chk("flags_dest", 8'h07, d);
    wr(ALU_FLAGS_OFFSET, 8'hf8);
    op(OP_CLEAR, 8'h00, 1'b1, 1'b0, 8'h00);
    rd(ALU_FLAGS_OFFSET);
    chk("flags_clear", 8'h0c, d);
    wr(ALU_FLAGS_OFFSET, 8'h35);
    foreach (keep[i]) begin
      op(keep[i], 8'h00, 1'b0, 1'b0, 8'h00);
      rd(ALU_FLAGS_OFFSET);
      chk("flags_kept", 8'h35, d);
    end
    $display("flag writes done");
  endtask
  task automatic t_ptr();
    logic [7:0] mode[3] = '{8'h10, 8'hb0, 8'h40};
    logic [7:0] e0[3] = '{8'h01, 8'h01, 8'h00};
    logic [7:0] e1[3] = '{8'hff, 8'hff, 8'h00};
    foreach (mode[i]) begin
      wr(ALU_FLAGS_OFFSET, mode[i]);
      ev(7'h03);
      chk("ptr0", e0[i], o_ptr0);
      chk("ptr1", e1[i], o_ptr1);
    end
    $display("pointer modes done");
  endtask
  task automatic t_cpu();
    wr(CPU_STATE_OFFSET, 8'h00);
    rd(CPU_STATE_OFFSET);
    chk("cpu_guarded", 8'h2c, d & 8'h3e);
    i_src_pending <= 4'h4;
    i_src_enable <= 4'h4;
    @(negedge i_clk_sys);
    chk("cpu_irq_on", 8'h01, {7'h00, o_cpu_irq});
    @(posedge i_clk_sys);
    i_src_enable <= 4'hb;
    @(negedge i_clk_sys);
    chk("cpu_irq_src", 8'h00, {7'h00, o_cpu_irq});
    @(posedge i_clk_sys);
    i_src_enable <= 4'h4;
    wr(CPU_STATE_OFFSET, 8'h10);
    chk("cpu_irq_off", 8'h00, {7'h00, o_cpu_irq});
    $display("cpu state done");
  endtask
  task automatic t_events();
    rd(IRQ_STATUS_OFFSET);
    chk("ovf_event", 8'h04, d & 8'h04);
    wr(IRQ_STATUS_OFFSET, 8'h04);
    ev(7'h40);
    ev(7'h10);
    rd(CPU_STATE_OFFSET);
    chk("cpu_events", 8'h00, d & 8'h0c);
    rd(IRQ_STATUS_OFFSET);
    chk("status_wdt", 8'h01, d);
    chk("irq_masked", 8'h00, {7'h00, o_irq});
    wr(IRQ_MASK_OFFSET, 8'h01);
    chk("irq_on", 8'h01, {7'h00, o_irq});
    wr(IRQ_STATUS_OFFSET, 8'h01);
    chk("irq_cleared", 8'h00, {7'h00, o_irq});
    ev(7'h20);
    rd(CPU_STATE_OFFSET);
    chk("cpu_wdt_clear", 8'h0c, d & 8'h0c);
    $display("events done");
  endtask
  task automatic t_resets();
    ev(7'h40);
    ev(7'h10);
    wr(CPU_STATE_OFFSET, 8'h13);
    do_reset(4'h4);
    rd(CPU_STATE_OFFSET);
    chk("pin_keep", 8'h32, d & 8'h3e);
    do_reset(4'h1);
    rd(CPU_STATE_OFFSET);
    chk("dip_flag", 8'h02, d & 8'h03);
    wr(CPU_STATE_OFFSET, 8'h03);
    rd(CPU_STATE_OFFSET);
    chk("sw_set", 8'h03, d & 8'h03);
    ev(7'h20);
    do_reset(4'h2);
    rd(CPU_STATE_OFFSET);
    chk("wdt_reset", 8'h02, d & 8'h0a);
    do_reset(4'h8);
    rd(CPU_STATE_OFFSET);
    chk("por_flags", 8'h3c, d & 8'h3e);
    rd(ALU_FLAGS_OFFSET);
    chk("por_alu", 8'hf0, d);
    $display("resets done");
  endtask
  task automatic t_stack();
    repeat (14) ev(7'h08);
    rd(CPU_STATE_OFFSET);
    chk("room_left", 8'h20, d & 8'h20);
    ev(7'h08);
    rd(CPU_STATE_OFFSET);
    chk("room_full", 8'h00, d & 8'h20);
    ev(7'h08);
    ev(7'h04);
    wr(CPU_STATE_OFFSET, 8'h3f);
    rd(CPU_STATE_OFFSET);
    chk("room_sticky", 8'h00, d & 8'h20);
    rd(IRQ_STATUS_OFFSET);
    chk("stack_event", 8'h02, d & 8'h02);
    $display("stack done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {i_rst_n, i_pin_reset, i_wdt_reset, i_dip_reset, i_wr, i_rd} = 6'h00;
    i_por_event = 1'b1;
    i_dip_detect_en = 1'b1;
    i_instr = '0;
    i_instr.imm_sel = 1'b1;
    {i_sleep_exec, i_wdt_clear_exec, i_wdt_timeout, i_stack_push, i_stack_pop, i_ptr0_access, i_ptr1_access} = 7'h00;
    {i_src_pending, i_src_enable, i_addr, i_wdata} = 24'h000000;
    @(posedge i_clk_sys);
    do_reset(4'h8);
    rd(CPU_STATE_OFFSET);
    chk("reset_cpu", 8'h3c, d & 8'h3e);
    t_arith();
    t_flags();
    t_ptr();
    t_cpu();
    t_events();
    t_resets();
    t_stack();
    conclude();
  end
  // run limit so a hang still ends in a verdict
  initial begin
    repeat (4000) @(posedge i_clk_sys);
    bad_count++;
    conclude();
  end
endmodule // alu_status_flags_tb
bind alu_status_flags alu_status_checker chk_inst (.i_clk_sys, .i_rst_n, .i_instr, .i_ptr0_access,
  .i_src_pending, .i_src_enable, .o_result, .o_result_valid, .o_accumulator, .o_ptr0, .o_cpu_irq);
